//--- sac_clkdiv.v
/*
 Converter clock divider: turns source clock ticks into converter
 clock ticks at one, two, four or eight source ticks per output.
 Assumes single-cycle source tick pulses on the core clock.
*/
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_clkdiv (
   input wire core_clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire clr_i,
   input wire src_tick_i,
   input wire [1:0] div_i,
   output reg conv_clk_tick_o
);
   reg [2:0] cnt_ff;
   reg [2:0] mask;

   // Terminal count for the selected ratio
   always @* begin
      case (div_i)
         2'h0: mask = 3'h0;
         2'h1: mask = 3'h1;
         2'h2: mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   // Counter restarts on clear so every conversion sees whole periods
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 3'h0;
         conv_clk_tick_o <= 1'b0;
      end else if (ce_i) begin
         if (clr_i) begin
            cnt_ff <= 3'h0;
            conv_clk_tick_o <= 1'b0;
         end else begin
            conv_clk_tick_o <= src_tick_i && (cnt_ff == mask); // RULE_05
            if (src_tick_i) begin
               cnt_ff <= (cnt_ff == mask) ? 3'h0 : cnt_ff + 3'h1;
            end
         end
      end
   end
endmodule

//--- sac_ctrl.v
/*
 Successive approximation converter control: clock select, start,
 continuous restart, abort, result formatting and half-read blocking.
 Assumes core_clk_i is the quad bus clock, comparator and oscillator
 tick inputs are synchronous, and register accesses arrive as strobes.
 Aborts land on the next core clock edge rather than asynchronously;
 at four core clocks per bus clock the difference is not visible to
 software. Result reads are strobes, one per software access.
*/
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_ctrl (
   // Clock, reset, enable and stop mode
   input wire core_clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire stop_i,
   // Status and control register write
   input wire csr_wr_i,
   input wire [4:0] csr_channel_i,
   input wire csr_continuous_i,
   input wire csr_irq_enable_i,
   // Clock configuration register write
   input wire ccfg_wr_i,
   input wire ccfg_async_sel_i,
   input wire ccfg_input_clk_sel_i,
   input wire [1:0] ccfg_div_i,
   input wire ccfg_long_sample_i,
   input wire ccfg_low_power_i,
   input wire ccfg_mode8_i,
   // Software result reads, oscillator and comparator
   input wire rd_high_i,
   input wire rd_low_i,
   input wire aclk_tick_i,
   input wire comp_i,
   // Analog front end controls
   output reg [4:0] channel_o,
   output reg sample_o,
   output reg [9:0] dac_code_o,
   output reg ref_enable_o,
   output reg aclk_enable_o,
   output reg low_power_o,
   // Result registers and status
   output reg [1:0] result_high_o,
   output reg [7:0] result_low_o,
   output reg conv_done_o,
   output reg conv_irq_o,
   output reg busy_o
);
   // Rounds a ten-bit code to eight bits, holding full scale at FF
   // Adding the first dropped bit gives round to nearest
   function [7:0] round8;
      input [9:0] r;
      begin
         if (r[9:2] == `SAC_LOW_FULL) begin
            round8 = `SAC_LOW_FULL;
         end else begin
            round8 = r[9:2] + {7'h00, r[1]};
         end
      end
   endfunction

   // Configuration held from the last register writes
   reg continuous_ff;
   reg irq_enable_ff;
   reg async_sel_ff;
   reg input_clk_sel_ff;
   reg [1:0] div_ff;
   reg long_sample_ff;
   reg mode8_ff;
   // Sequencer state
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [5:0] cnt_ff;
   reg [5:0] nxt_cnt;
   reg [3:0] bit_ff;
   reg [3:0] nxt_bit;
   reg [9:0] sar_ff;
   reg [9:0] nxt_sar;
   reg [9:0] nxt_dac;
   // Bus clock phase and half-read latch
   reg [1:0] bus_div_ff;
   reg half_read_ff;
   // Combinational helpers
   reg nxt_done;
   reg xfer;
   reg [9:0] sar_bit;
   reg [5:0] samp_len;
   // Clock ticks and register strobe decodes
   wire bus_tick;
   wire src_tick;
   wire conv_clk_tick;
   wire abort;
   wire start;

   // Bus clock is the core clock divided by four; it halts in stop
   assign bus_tick = (bus_div_ff == `SAC_BUS_DIV_LAST) && !stop_i;

   // Async ticks, else alternate (core, four times bus) or bus clock
   assign src_tick = async_sel_ff ? aclk_tick_i : // RULE_04 RULE_07
      (input_clk_sel_ff ? bus_tick : 1'b1); // RULE_26

   // Any register write or stop without the async clock aborts
   assign abort = csr_wr_i || ccfg_wr_i ||
      (stop_i && !async_sel_ff); // RULE_16
   // Only software writes start conversions; there is no trigger pin
   assign start = csr_wr_i && (csr_channel_i != `SAC_CH_OFF); // RULE_10 RULE_11

   sac_clkdiv u_div (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .clr_i(state_ff == `SAC_ST_IDLE),
      .src_tick_i(src_tick),
      .div_i(div_ff),
      .conv_clk_tick_o(conv_clk_tick)
   );

   // Register writes and the bus clock divider
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         channel_o <= `SAC_CH_OFF;
         continuous_ff <= 1'b0;
         irq_enable_ff <= 1'b0;
         async_sel_ff <= 1'b0;
         input_clk_sel_ff <= 1'b0;
         div_ff <= 2'h0;
         long_sample_ff <= 1'b0;
         low_power_o <= 1'b0;
         mode8_ff <= 1'b0;
         bus_div_ff <= 2'h0;
      end else if (ce_i) begin
         // Bus phase runs free, so sync length varies by up to three core clocks
         bus_div_ff <= bus_div_ff + 2'h1;
         if (csr_wr_i) begin
            channel_o <= csr_channel_i; // RULE_08
            continuous_ff <= csr_continuous_i;
            irq_enable_ff <= csr_irq_enable_i;
         end
         if (ccfg_wr_i) begin
            async_sel_ff <= ccfg_async_sel_i;
            input_clk_sel_ff <= ccfg_input_clk_sel_i;
            div_ff <= ccfg_div_i;
            long_sample_ff <= ccfg_long_sample_i;
            low_power_o <= ccfg_low_power_i; // RULE_06
            mode8_ff <= ccfg_mode8_i; // RULE_09
         end
      end
   end

   // Sample window length per resolution and sample time
   always @* begin
      samp_len = mode8_ff ? `SAC_SAMP_8 : `SAC_SAMP_10; // RULE_19 RULE_21
      // Long sampling adds a fixed number of converter clocks
      if (long_sample_ff) begin
         samp_len = samp_len + `SAC_SAMP_LONG; // RULE_20 RULE_22
      end
   end

   // Sequencer: sync, warm-up, sample, ten approximation steps
   always @* begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      nxt_sar = sar_ff;
      nxt_dac = dac_code_o;
      sar_bit = 10'h000;
      xfer = 1'b0;
      if (abort) begin
         // Restart or fall idle; results are left untouched
         nxt_state = start ? `SAC_ST_SYNC : `SAC_ST_IDLE; // RULE_18 RULE_25
         nxt_cnt = 6'h00;
         nxt_dac = 10'h000;
      end else begin
         case (state_ff)
            `SAC_ST_IDLE: begin
               // Parked with clocks and references off
               nxt_state = `SAC_ST_IDLE;
            end
            `SAC_ST_SYNC: begin
               // Three bus clocks align the start with the bus
               if (bus_tick) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  if (cnt_ff[2:0] == `SAC_SYNC_BUS - 3'h1) begin
                     nxt_state = `SAC_ST_WARM; // RULE_24
                     nxt_cnt = 6'h00;
                  end
               end
            end
            `SAC_ST_WARM: begin
               // Waits on converter ticks, so async start-up is absorbed
               if (conv_clk_tick) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  if (cnt_ff == `SAC_WARM_CCLK - 6'h01) begin
                     nxt_state = `SAC_ST_SAMP; // RULE_23
                     nxt_cnt = 6'h00;
                  end
               end
            end
            `SAC_ST_SAMP: begin
               if (conv_clk_tick) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  if (cnt_ff == samp_len - 6'h01) begin
                     nxt_state = `SAC_ST_CONV;
                     nxt_bit = `SAC_TOP_BIT;
                     nxt_sar = 10'h000;
                     // First trial code is mid scale
                     nxt_dac = `SAC_DAC_MID;
                  end
               end
            end
            `SAC_ST_CONV: begin
               if (conv_clk_tick) begin
                  // Keep the trial bit when input is at or above it
                  nxt_sar = comp_i ? dac_code_o : sar_ff; // RULE_01
                  if (bit_ff == 4'h0) begin
                     xfer = 1'b1;
                     nxt_dac = 10'h000;
                     nxt_cnt = 6'h00;
                     // Blocked transfers restart regardless of mode
                     if (continuous_ff || (half_read_ff && !mode8_ff)) begin
                        nxt_state = `SAC_ST_SAMP; // RULE_12 RULE_14
                     end else begin
                        nxt_state = `SAC_ST_IDLE;
                     end
                  end else begin
                     // Next trial: kept bits plus the next lower bit
                     nxt_bit = bit_ff - 4'h1;
                     sar_bit = 10'h001 << nxt_bit;
                     nxt_dac = nxt_sar | sar_bit;
                  end
               end
            end
            default: begin
               // Unused codes fall back to idle
               nxt_state = `SAC_ST_IDLE;
            end
         endcase
      end
   end

   // Done flag: transfer sets it, a starting write clears it
   always @* begin
      nxt_done = conv_done_o;
      if (start) begin
         nxt_done = 1'b0; // RULE_27
      end
      // Set wins, though a start always aborts so both never meet
      if (xfer && !(half_read_ff && !mode8_ff)) begin
         nxt_done = 1'b1; // RULE_03
      end
   end

   // Sequencer, result registers and status outputs
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= `SAC_ST_IDLE;
         cnt_ff <= 6'h00;
         bit_ff <= 4'h0;
         sar_ff <= 10'h000;
         dac_code_o <= 10'h000;
         // Results return to their reset values, unlike an abort
         result_high_o <= `SAC_RES_HI_RST; // RULE_17
         result_low_o <= `SAC_RES_LO_RST;
         half_read_ff <= 1'b0;
         conv_done_o <= 1'b0;
         conv_irq_o <= 1'b0;
         sample_o <= 1'b0;
         ref_enable_o <= 1'b0;
         aclk_enable_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         // Sequencer registers advance only with the clock enable
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
         sar_ff <= nxt_sar;
         dac_code_o <= nxt_dac;
         // Reading high arms the block until low is read
         if (rd_low_i) begin
            half_read_ff <= 1'b0;
         end else if (rd_high_i) begin
            half_read_ff <= 1'b1; // RULE_13
         end
         // A blocked transfer drops the new result and keeps the old
         if (xfer && !(half_read_ff && !mode8_ff)) begin // RULE_13
            if (mode8_ff) begin
               result_high_o <= 2'h0;
               result_low_o <= round8(nxt_sar); // RULE_02
            end else begin
               result_high_o <= nxt_sar[9:8]; // RULE_02
               result_low_o <= nxt_sar[7:0];
            end
         end
         // Status outputs are registered so every output is a flop
         conv_done_o <= nxt_done;
         conv_irq_o <= nxt_done && irq_enable_ff; // RULE_03
         sample_o <= (nxt_state == `SAC_ST_SAMP);
         ref_enable_o <= (nxt_state != `SAC_ST_IDLE); // RULE_18
         // Oscillator only runs during a conversion using it
         aclk_enable_o <= (nxt_state != `SAC_ST_IDLE) && async_sel_ff; // RULE_06
         busy_o <= (nxt_state != `SAC_ST_IDLE);
      end
   end
endmodule

//--- sac_ctrl_bench.sv
/*
 Self-checking bench for the converter control block.
 Assumes sac_ctrl ports as declared and a 250 MHz core clock.
*/
`timescale 1ns/1ps
module sac_ctrl_bench;
   reg core_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg stp = 1'b0, cw = 1'b0, kw = 1'b0, rdh = 1'b0, rdl = 1'b0;
   reg cont = 1'b0, ien = 1'b0, asel = 1'b0, isel = 1'b0, lsmp = 1'b0;
   reg m8 = 1'b0, atk = 1'b0, comp = 1'b0, ce = 1'b1;
   reg [4:0] ch = 5'h1F;
   reg [1:0] dv = 2'h0;
   reg [9:0] vin = 10'h000;
   reg [3:0] tc = 4'h0;
   wire [4:0] chan;
   wire [9:0] dac;
   wire [1:0] rh;
   wire [7:0] rl;
   wire smp, refe, acke, lp, done, irq, busy;
   integer error_cnt = 0, n_compared = 0;
   sac_ctrl uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
      .stop_i(stp), .csr_wr_i(cw), .csr_channel_i(ch),
      .csr_continuous_i(cont), .csr_irq_enable_i(ien), .ccfg_wr_i(kw),
      .ccfg_async_sel_i(asel), .ccfg_input_clk_sel_i(isel),
      .ccfg_div_i(dv), .ccfg_long_sample_i(lsmp),
      .ccfg_low_power_i(lsmp), .ccfg_mode8_i(m8), .rd_high_i(rdh),
      .rd_low_i(rdl), .aclk_tick_i(atk), .comp_i(comp), .channel_o(chan),
      .sample_o(smp), .dac_code_o(dac), .ref_enable_o(refe),
      .aclk_enable_o(acke), .low_power_o(lp), .result_high_o(rh),
      .result_low_o(rl), .conv_done_o(done), .conv_irq_o(irq),
      .busy_o(busy));
   always #2 core_clk_i = ~core_clk_i;
   // Ideal comparator; oscillator ticks every 10 cycles only when enabled
   always @(negedge core_clk_i) begin
      comp <= (vin >= dac);
      tc <= (tc == 4'h9) ? 4'h0 : tc + 4'h1;
      atk <= acke && (tc == 4'h9);
   end
   task summarize;
      begin
         if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [23:0] got, input [23:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Bounded wait on a level; a hang ends the run
   task wt(input lvl, input sel, inout integer n);
      begin
         while ((sel ? smp : done) !== lvl && n < 3000) begin
            @(negedge core_clk_i);
            n = n + 1;
         end
         if (n >= 3000) begin
            error_cnt = error_cnt + 1;
            summarize;
         end
      end
   endtask
   task csr(input [4:0] c, input co, input ie);
      begin
         ch = c;
         cont = co;
         ien = ie;
         cw = 1'b1;
         @(negedge core_clk_i);
         cw = 1'b0;
      end
   endtask
   task cfg(input a, input i, input [1:0] d, input l, input m);
      begin
         asel = a;
         isel = i;
         dv = d;
         lsmp = l;
         m8 = m;
         kw = 1'b1;
         @(negedge core_clk_i);
         kw = 1'b0;
      end
   endtask
   // One single conversion, timed against its clock-count limit
   task conv(input m, l, i, a, input [1:0] d, input [9:0] v, e);
      integer n, pd, lo;
      begin
         cfg(a, i, d, l, m);
         vin = v;
         csr(5'h03, 1'b0, 1'b1);
         n = 0;
         wt(1'b1, 1'b0, n);
         pd = (a ? 10 : (i ? 4 : 1)) << d;
         lo = (m ? (l ? 38 : 18) : (l ? 41 : 21)) * pd;
         chk({lp, chan, busy, done, irq, rh, rl}, {l, 5'h03, 3'h3, e});
         // Fourteen cycles beyond the limit, ten more on async, cover the bus sync, strobe capture and the divider
         chk(n + pd >= lo && n <= lo + 14 + (a ? 10 : 0), 1'b1);
      end
   endtask
   task blocked;
      integer n;
      begin
         cfg(1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
         vin = 10'h111;
         csr(5'h05, 1'b0, 1'b0);
         n = 0;
         wt(1'b1, 1'b0, n);
         vin = 10'h222;
         csr(5'h05, 1'b0, 1'b0);
         rdh = 1'b1;
         @(negedge core_clk_i);
         rdh = 1'b0;
         repeat (80) @(negedge core_clk_i);
         chk({busy, done, rh, rl}, {2'h2, 10'h111});
         rdl = 1'b1;
         @(negedge core_clk_i);
         rdl = 1'b0;
         wt(1'b1, 1'b0, n);
         chk({done, rh, rl}, {1'b1, 10'h222});
      end
   endtask
   task contin;
      integer n;
      reg [11:0] snap;
      begin
         vin = 10'h0F0;
         csr(5'h07, 1'b1, 1'b0);
         n = 0;
         wt(1'b1, 1'b0, n);
         wt(1'b1, 1'b1, n);
         n = 0;
         wt(1'b0, 1'b1, n);
         wt(1'b1, 1'b1, n);
         chk(n >= 16 && n <= 19, 1'b1);
         chk({busy, done, irq, rh, rl}, {3'h6, 10'h0F0});
         // Clock enable low freezes the sequencer mid-conversion
         ce = 1'b0;
         snap = {smp, busy, dac};
         repeat (12) @(negedge core_clk_i);
         chk({smp, busy, dac}, snap);
         ce = 1'b1;
         csr(5'h1F, 1'b0, 1'b0);
         chk({busy, refe, dac, rh, rl}, {2'h0, 10'h0, 10'h0F0});
      end
   endtask
   task aborts;
      integer n;
      begin
         cfg(1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
         vin = 10'h3C3;
         csr(5'h02, 1'b0, 1'b0);
         repeat (40) @(negedge core_clk_i);
         cfg(1'b0, 1'b1, 2'h3, 1'b1, 1'b0);
         chk({busy, refe, dac, rh, rl}, {2'h0, 10'h0, 10'h0F0});
         csr(5'h02, 1'b0, 1'b0);
         repeat (40) @(negedge core_clk_i);
         stp = 1'b1;
         @(negedge core_clk_i);
         stp = 1'b0;
         chk({busy, rh, rl}, {1'b0, 10'h0F0});
         // Stop only after sync, since stop also halts the bus clock
         cfg(1'b1, 1'b0, 2'h0, 1'b0, 1'b0);
         csr(5'h02, 1'b0, 1'b0);
         repeat (20) @(negedge core_clk_i);
         stp = 1'b1;
         chk(acke, 1'b1);
         n = 0;
         wt(1'b1, 1'b0, n);
         chk({acke, busy, rh, rl}, {2'h0, 10'h3C3});
         stp = 1'b0;
         csr(5'h02, 1'b0, 1'b0);
         repeat (20) @(negedge core_clk_i);
         rst_i = 1'b1;
         repeat (2) @(negedge core_clk_i);
         rst_i = 1'b0;
         chk({chan, busy, done, rh, rl}, {5'h1F, 2'h0, 10'h0});
      end
   endtask
   initial begin
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk({chan, busy, done, irq, rh, rl}, {5'h1F, 13'h0});
      conv(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 10'h2A6, 10'h2A6);
      conv(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 10'h2A6, 10'h0AA);
      conv(1'b1, 1'b1, 1'b1, 1'b0, 2'h1, 10'h3FF, 10'h0FF);
      conv(1'b0, 1'b1, 1'b1, 1'b0, 2'h2, 10'h000, 10'h000);
      conv(1'b0, 1'b0, 1'b0, 1'b0, 2'h3, 10'h3FF, 10'h3FF);
      conv(1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 10'h155, 10'h055);
      blocked;
      contin;
      aborts;
      summarize;
   end
endmodule

//--- sac_ctrl_sva.sv
/*
 Checker for the converter control block: start, idle, abort, result
 hold and flag relations. Assumes sac_ctrl port names; bound below.
*/
`timescale 1ns/1ps
module sac_ctrl_sva (
   input wire core_clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire stop_i,
   input wire csr_wr_i,
   input wire [4:0] csr_channel_i,
   input wire ccfg_wr_i,
   input wire [9:0] dac_code_o,
   input wire ref_enable_o,
   input wire aclk_enable_o,
   input wire [1:0] result_high_o,
   input wire [7:0] result_low_o,
   input wire conv_done_o,
   input wire conv_irq_o,
   input wire busy_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Strobe kinds and the quiet state that aborts must reach
   sequence s_start;
      ce_i && csr_wr_i && csr_channel_i != 5'h1F;
   endsequence
   sequence s_off;
      ce_i && csr_wr_i && csr_channel_i == 5'h1F;
   endsequence
   sequence s_idle;
      !busy_o && !ref_enable_o && !aclk_enable_o && dac_code_o == 10'h000;
   endsequence
   a_start_runs: assert property (
      s_start |=> busy_o && ref_enable_o && !conv_done_o) else $error("no start");
   a_off_idles: assert property (
      s_off |=> s_idle) else $error("off write not idle");
   a_cfg_abort: assert property (
      ce_i && ccfg_wr_i |=> s_idle) else $error("config write no abort");
   a_stop_abort: assert property (
      ce_i && stop_i && busy_o && !aclk_enable_o && !csr_wr_i |=> !busy_o)
      else $error("stop did not abort");
   a_idle_hold: assert property (
      !busy_o |=> $stable(result_low_o) && $stable(result_high_o))
      else $error("result moved while idle");
   a_done_cause: assert property (
      $rose(conv_done_o) |-> $past(busy_o)) else $error("flag without work");
   a_irq_flag: assert property (
      conv_irq_o |-> conv_done_o) else $error("irq without flag");
   a_aclk_busy: assert property (
      aclk_enable_o |-> busy_o && ref_enable_o) else $error("osc runs idle");
endmodule

bind sac_ctrl sac_ctrl_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .stop_i(stop_i), .csr_wr_i(csr_wr_i),
   .csr_channel_i(csr_channel_i), .ccfg_wr_i(ccfg_wr_i),
   .dac_code_o(dac_code_o), .ref_enable_o(ref_enable_o),
   .aclk_enable_o(aclk_enable_o), .result_high_o(result_high_o),
   .result_low_o(result_low_o), .conv_done_o(conv_done_o),
   .conv_irq_o(conv_irq_o), .busy_o(busy_o));

//--- sac_map.vh
/*
 Constants for the successive approximation converter control block:
 field widths, reset values, state codes and conversion timing counts.
 Assumes it is included by the design files and holds definitions only.
*/
// Summary of operation
// [RULE_01] Inputs beyond references saturate to full or zero
// [RULE_02] Ten-bit result split; eight-bit rounded into low
// [RULE_03] Transfer sets done flag; interrupt when enabled
// [RULE_04] Source clock chosen by async and input select
// [RULE_05] Source divided by one, two, four, eight
// [RULE_06] Async clock runs only while converting on it
// [RULE_07] Async clock keeps converting during stop mode; a conversion still in bus sync waits until stop ends
// [RULE_08] One channel converted, picked by channel field
// [RULE_09] Resolution mode picks ten or eight bits
// [RULE_10] Status write with channel not all ones starts
// [RULE_11] No hardware trigger; software or continuous only
// [RULE_12] Continuous mode restarts after every transfer
// [RULE_13] Half-read ten-bit result blocks next transfer
// [RULE_14] Blocked transfer restarts even in single mode
// [RULE_15] Software avoids result reads during single conversion
// [RULE_16] Status write, clock write, reset, stop abort
// [RULE_17] Abort keeps last result; reset clears it
// [RULE_18] Reset or abort drops to inactive low power
// [RULE_19] Eight-bit short sample: 18 first, 16 later
// [RULE_20] Eight-bit long sample: 38 first, 36 later
// [RULE_21] Ten-bit short sample: 21 first, 19 later
// [RULE_22] Ten-bit long sample: 41 first, 39 later
// [RULE_23] Async first conversion allows clock start-up time
// [RULE_24] First conversion adds three bus clock sync
// [RULE_25] All-ones channel write leaves converter idle
// [RULE_26] Alternate source is four times bus clock
// [RULE_27] Starting write clears the done flag
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

`define SAC_CH_W 5
`define SAC_CH_OFF 5'h1F
`define SAC_RES_W 10
`define SAC_RES_RST 10'h000
`define SAC_RES_HI_RST 2'h0
`define SAC_RES_LO_RST 8'h00
`define SAC_LOW_FULL 8'hFF
`define SAC_TOP_BIT 4'h9
`define SAC_DAC_MID 10'h200

// Core clock is the quad bus clock; bus clock is one tick in four
`define SAC_BUS_DIV_LAST 2'h3
`define SAC_SYNC_BUS 3'h3
`define SAC_WARM_CCLK 6'h02
`define SAC_SAMP_10 6'h09
`define SAC_SAMP_8 6'h06
`define SAC_SAMP_LONG 6'h14

`define SAC_ST_IDLE 3'h0
`define SAC_ST_SYNC 3'h1
`define SAC_ST_WARM 3'h2
`define SAC_ST_SAMP 3'h3
`define SAC_ST_CONV 3'h4

`endif
